// [design/mccr_regs.sv]
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - AC offsets clear to zero at reset
// - Calibration writes offsets after 6N+30 ADC cycles
// - Data ready set when calibration completes
// - AC offsets are signed 24-bit fractions
// - Third pulse rate resets to 512000 Hz
// - Third pulse rate has five fractional bits
// - Rate clamps to divided clock over eight
// - Temperature register follows sensor results
// - Temperature is signed, 16 fractional bits
// - System gain resets to 1.25
// - System gain signed, two integer bits
// - Pulse width used in alternate/mechanical formats
// - Sample period is 1024 divided clocks
// - Pulse width resets to 512 samples
// - Sag averages magnitudes, 23-bit count
// - Zero sag count disables sag detection
// - Average below threshold flags a sag
// - Sag threshold unsigned, top bit zero
// - Data ready lives in status bit 23
// - Sag flag lives in status bit 1
module mccr_regs
  import mccr_pkg::*;
#(
  parameter int unsigned K_DIV = 1
) (
  input  wire logic        MCLK,
  input  wire logic        RST_B,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        ADC_STROBE,
  input  wire logic [23:0] I_SAMPLE,
  input  wire logic [23:0] V_SAMPLE,
  input  wire logic        TEMP_VALID,
  input  wire logic [23:0] TEMP_DATA,
  input  wire logic        FMT_ALT,
  input  wire logic        FMT_MECH,
  output logic      [23:0] I_AC_OFFSET,
  output logic      [23:0] V_AC_OFFSET,
  output logic      [23:0] SYS_GAIN,
  output logic      [23:0] P3_RATE,
  output logic      [23:0] E12_LOW_WIDTH,
  output logic             E12_WIDTH_EN,
  output logic             SAMPLE_TICK,
  output logic             DATA_READY,
  output logic             VOLTAGE_SAG,
  output logic             CAL_BUSY
);

  localparam longint unsigned P3_LIM_RAW =
    (MCLK_HZ / K_DIV / P3_CLAMP_DIV) << P3_FRAC_BITS;
  localparam logic [23:0] P3_LIMIT =
    (P3_LIM_RAW > 64'h0000_0000_00FF_FFFF) ? 24'hFFFFFF : P3_LIM_RAW[23:0];

  logic [23:0] current_ac_offset;
  logic [23:0] voltage_ac_offset;
  logic [23:0] third_pulse_rate;
  logic signed [23:0] temperature_result;
  logic [23:0] system_gain;
  logic [23:0] energy_pulse_width;
  logic [22:0] sag_sample_count;
  logic [22:0] sag_threshold;
  logic [23:0] cycle_count;
  logic [23:0] status;
  logic        wr_en;
  logic        rd_en;
  logic [5:0]  idx;
  logic [31:0] next_prdata;
  logic        next_err;
  mccr_cal_state_t cal_state;
  logic [26:0] cal_cnt;
  logic [26:0] cal_last;
  logic        cal_done;
  logic signed [23:0] avg_i;
  logic signed [23:0] avg_v;
  logic signed [23:0] next_avg_i;
  logic signed [23:0] next_avg_v;
  logic [22:0] sag_n;
  logic [46:0] sag_acc;
  logic [23:0] v_mag;
  logic [46:0] next_sum;
  logic        sag_event;
  logic [15:0] k_cnt;
  logic [9:0]  smp_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait-free access phase, answer registered
  assign idx   = PADDR[7:2];
  assign wr_en = PSEL && PENABLE && PREADY && PWRITE;
  assign rd_en = PSEL && !PENABLE && !PREADY;

  always_comb begin
    next_err    = 1'b0;
    next_prdata = 32'h00000000;
    case (idx)
      IDX_STATUS:      next_prdata = {8'h00, status};
      IDX_I_ACOFF:     next_prdata = {8'h00, current_ac_offset};
      IDX_V_ACOFF:     next_prdata = {8'h00, voltage_ac_offset};
      IDX_P3_RATE:     next_prdata = {8'h00, third_pulse_rate};
      IDX_TEMP:        next_prdata = {8'h00, temperature_result};
      IDX_SYS_GAIN:    next_prdata = {8'h00, system_gain};
      IDX_PULSE_WIDTH: next_prdata = {8'h00, energy_pulse_width};
      IDX_SAG_COUNT:   next_prdata = {9'h000, sag_sample_count};
      IDX_SAG_LEVEL:   next_prdata = {9'h000, sag_threshold};
      IDX_CAL_CMD:     next_prdata = {31'h00000000, CAL_BUSY};
      IDX_CYCLE_COUNT: next_prdata = {8'h00, cycle_count};
      default:         next_err    = 1'b1;
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= rd_en;
      if (rd_en) begin
        PRDATA  <= PWRITE ? 32'h00000000 : next_prdata;
        PSLVERR <= next_err;
      end else begin
        PSLVERR <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-owned configuration; each holds until rewritten
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      third_pulse_rate   <= P3_RATE_RST;
      system_gain        <= SYS_GAIN_RST;
      energy_pulse_width <= PULSE_WIDTH_RST;
      sag_sample_count   <= SAG_COUNT_RST[22:0];
      sag_threshold      <= SAG_LEVEL_RST[22:0];
      cycle_count        <= CYCLE_COUNT_RST;
    end else if (wr_en) begin
      case (idx)
        IDX_P3_RATE:     third_pulse_rate   <= PWDATA[23:0];
        IDX_SYS_GAIN:    system_gain        <= PWDATA[23:0];
        IDX_PULSE_WIDTH: energy_pulse_width <= PWDATA[23:0];
        IDX_SAG_COUNT:   sag_sample_count   <= PWDATA[22:0];
        IDX_SAG_LEVEL:   sag_threshold      <= PWDATA[22:0];
        IDX_CYCLE_COUNT: cycle_count        <= PWDATA[23:0];
        default: ;
      endcase
    end
  end

  // Calibration result beats a software write landing in the same cycle
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      current_ac_offset <= ACOFF_RST;
      voltage_ac_offset <= ACOFF_RST;
    end else if (cal_done) begin
      // Negating -1.0 would wrap, so it saturates to the largest fraction
      current_ac_offset <= (next_avg_i == 24'sh800000) ? 24'h7FFFFF : -next_avg_i;
      voltage_ac_offset <= (next_avg_v == 24'sh800000) ? 24'h7FFFFF : -next_avg_v;
    end else if (wr_en && idx == IDX_I_ACOFF) begin
      current_ac_offset <= PWDATA[23:0];
    end else if (wr_en && idx == IDX_V_ACOFF) begin
      voltage_ac_offset <= PWDATA[23:0];
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      temperature_result <= TEMP_RST;
    end else if (TEMP_VALID) begin
      temperature_result <= TEMP_DATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AC offset calibration: leaky average of each channel over 6N+30 cycles
  assign next_avg_i = avg_i + 24'(($signed({I_SAMPLE[23], I_SAMPLE}) -
                      $signed({avg_i[23], avg_i})) >>> CAL_AVG_SHIFT);
  assign next_avg_v = avg_v + 24'(($signed({V_SAMPLE[23], V_SAMPLE}) -
                      $signed({avg_v[23], avg_v})) >>> CAL_AVG_SHIFT);
  assign cal_done   = (cal_state == CAL_RUN) && ADC_STROBE && (cal_cnt == cal_last);

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      cal_state <= CAL_IDLE;
      cal_cnt   <= 27'h0000000;
      cal_last  <= 27'h0000000;
      avg_i     <= 24'sh000000;
      avg_v     <= 24'sh000000;
    end else begin
      case (cal_state)
        CAL_IDLE: begin
          // A start while busy is ignored, so the length cannot be stretched
          if (wr_en && idx == IDX_CAL_CMD && PWDATA[CAL_START_BIT]) begin
            cal_state <= CAL_RUN;
            cal_cnt   <= 27'h0000000;
            cal_last  <= 27'(CAL_MULT) * {3'b000, cycle_count}
                         + 27'(CAL_EXTRA) - 27'h0000001;
            avg_i     <= 24'sh000000;
            avg_v     <= 24'sh000000;
          end
        end
        CAL_RUN: begin
          if (ADC_STROBE) begin
            avg_i   <= next_avg_i;
            avg_v   <= next_avg_v;
            cal_cnt <= cal_cnt + 27'h0000001;
            if (cal_done) begin
              cal_state <= CAL_IDLE;
            end
          end
        end
        default: cal_state <= CAL_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sag detection on voltage magnitude
  assign v_mag    = V_SAMPLE[23] ? (~V_SAMPLE + 24'h000001) : V_SAMPLE;
  assign next_sum = sag_acc + {23'h000000, v_mag};
  // Compare sum against level times count rather than divide
  assign sag_event = ADC_STROBE && (sag_sample_count != 23'h000000)
                     && (sag_n == sag_sample_count - 23'h000001)
                     && (next_sum < (sag_threshold * {24'h000000, sag_sample_count}));

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      sag_n   <= 23'h000000;
      sag_acc <= 47'h000000000000;
    end else if (sag_sample_count == 23'h000000) begin
      sag_n   <= 23'h000000;
      sag_acc <= 47'h000000000000;
    end else if (ADC_STROBE) begin
      if (sag_n >= sag_sample_count - 23'h000001) begin
        sag_n   <= 23'h000000;
        sag_acc <= 47'h000000000000;
      end else begin
        sag_n   <= sag_n + 23'h000001;
        sag_acc <= next_sum;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status: hardware set wins over write-one-to-clear
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      status <= STATUS_RST;
    end else begin
      if (cal_done) begin
        status[STATUS_RDY_BIT] <= 1'b1;
      end else if (wr_en && idx == IDX_STATUS && PWDATA[STATUS_RDY_BIT]) begin
        status[STATUS_RDY_BIT] <= 1'b0;
      end
      if (sag_event) begin
        status[STATUS_SAG_BIT] <= 1'b1;
      end else if (wr_en && idx == IDX_STATUS && PWDATA[STATUS_SAG_BIT]) begin
        status[STATUS_SAG_BIT] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divided clock and sample period tick
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      k_cnt       <= 16'h0000;
      smp_cnt     <= 10'h000;
      SAMPLE_TICK <= 1'b0;
    end else begin
      SAMPLE_TICK <= 1'b0;
      if (k_cnt == 16'(K_DIV - 1)) begin
        k_cnt   <= 16'h0000;
        smp_cnt <= smp_cnt + 10'h001;
        if (smp_cnt == 10'(SAMPLE_PERIOD - 1)) begin
          SAMPLE_TICK <= 1'b1;
        end
      end else begin
        k_cnt <= k_cnt + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs toward pulse generators and datapath
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      P3_RATE       <= 24'h000000;
      E12_LOW_WIDTH <= 24'h000000;
      E12_WIDTH_EN  <= 1'b0;
      DATA_READY    <= 1'b0;
      VOLTAGE_SAG   <= 1'b0;
      CAL_BUSY      <= 1'b0;
    end else begin
      // Unsigned 19.5 compare needs no alignment: both share the format
      P3_RATE       <= (third_pulse_rate > P3_LIMIT) ? P3_LIMIT : third_pulse_rate;
      E12_WIDTH_EN  <= FMT_ALT || FMT_MECH;
      E12_LOW_WIDTH <= (FMT_ALT || FMT_MECH) ? energy_pulse_width : 24'h000000;
      DATA_READY    <= status[STATUS_RDY_BIT];
      VOLTAGE_SAG   <= status[STATUS_SAG_BIT];
      CAL_BUSY      <= (cal_state == CAL_RUN) && !cal_done;
    end
  end

  assign I_AC_OFFSET = current_ac_offset;
  assign V_AC_OFFSET = voltage_ac_offset;
  assign SYS_GAIN    = system_gain;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_B);

  a_offset_hold: assert property (
    !cal_done && !(wr_en && (idx == IDX_I_ACOFF || idx == IDX_V_ACOFF))
    |=> $stable(current_ac_offset) && $stable(voltage_ac_offset))
    else $error("AC offset changed without cause");

  a_offset_reset_zero: assert property (
    $rose(RST_B) |-> (current_ac_offset == 24'h000000) && (voltage_ac_offset == 24'h000000))
    else $error("AC offset not zero after reset");

  a_cal_length: assert property (
    cal_done |-> cal_last == 27'(CAL_MULT) * {3'b000, cycle_count} + 27'(CAL_EXTRA) - 27'h0000001)
    else $error("Calibration length wrong");

  a_cal_sets_ready: assert property (
    cal_done |=> status[STATUS_RDY_BIT] ##1 DATA_READY)
    else $error("Data ready missing after calibration");

  // Sampled reset in the antecedent skips the edge where the output still holds reset
  a_rate_clamp: assert property (
    RST_B |=> P3_RATE == (($past(third_pulse_rate) > P3_LIMIT) ? P3_LIMIT
                                                               : $past(third_pulse_rate)))
    else $error("Third pulse rate not clamped");

  a_gain_reset: assert property (
    $rose(RST_B) |-> system_gain == SYS_GAIN_RST && energy_pulse_width == PULSE_WIDTH_RST)
    else $error("Gain or width reset value wrong");

  a_sag_disabled: assert property (
    sag_sample_count == 23'h000000 && !status[STATUS_SAG_BIT] && !wr_en
    |=> !status[STATUS_SAG_BIT])
    else $error("Sag flagged while disabled");

  a_sag_flag: assert property (
    sag_event |=> status[STATUS_SAG_BIT] ##1 VOLTAGE_SAG)
    else $error("Sag flag not raised");

  a_width_gate: assert property (
    !(FMT_ALT || FMT_MECH) |=> !E12_WIDTH_EN && E12_LOW_WIDTH == 24'h000000)
    else $error("Pulse width used in wrong format");

  a_sample_tick: assert property (
    SAMPLE_TICK |-> ##1 (!SAMPLE_TICK) [*8])
    else $error("Sample tick too frequent");

  a_temp_update: assert property (
    TEMP_VALID |=> temperature_result == $past(TEMP_DATA))
    else $error("Temperature not updated");

endmodule : mccr_regs

// [design/mccr_pkg.sv]
package mccr_pkg;

  localparam int unsigned REG_W = 24;

  // Register indexes; the byte address is four times the index
  localparam logic [5:0] IDX_STATUS      = 6'h0F;
  localparam logic [5:0] IDX_I_ACOFF     = 6'h10;
  localparam logic [5:0] IDX_V_ACOFF     = 6'h11;
  localparam logic [5:0] IDX_P3_RATE     = 6'h12;
  localparam logic [5:0] IDX_TEMP        = 6'h13;
  localparam logic [5:0] IDX_SYS_GAIN    = 6'h14;
  localparam logic [5:0] IDX_PULSE_WIDTH = 6'h15;
  localparam logic [5:0] IDX_SAG_COUNT   = 6'h17;
  localparam logic [5:0] IDX_SAG_LEVEL   = 6'h18;
  localparam logic [5:0] IDX_CAL_CMD     = 6'h20;
  localparam logic [5:0] IDX_CYCLE_COUNT = 6'h21;

  // Values after reset
  localparam logic [23:0] ACOFF_RST       = 24'h000000;
  localparam logic [23:0] P3_RATE_RST     = 24'hFA0000;
  localparam logic [23:0] TEMP_RST        = 24'h000000;
  localparam logic [23:0] SYS_GAIN_RST    = 24'h500000;
  localparam logic [23:0] PULSE_WIDTH_RST = 24'h000200;
  localparam logic [23:0] SAG_COUNT_RST   = 24'h000000;
  localparam logic [23:0] SAG_LEVEL_RST   = 24'h000000;
  localparam logic [23:0] CYCLE_COUNT_RST = 24'h000FA0;
  localparam logic [23:0] STATUS_RST      = 24'h000000;

  // Field positions
  localparam int unsigned STATUS_RDY_BIT  = 23;
  localparam int unsigned STATUS_SAG_BIT  = 1;
  localparam int unsigned CAL_START_BIT   = 0;
  localparam int unsigned P3_FRAC_BITS    = 5;

  // Counts
  localparam int unsigned CAL_MULT      = 6;
  localparam int unsigned CAL_EXTRA     = 30;
  localparam int unsigned SAMPLE_PERIOD = 1024;
  localparam int unsigned P3_CLAMP_DIV  = 8;
  localparam int unsigned CAL_AVG_SHIFT = 4;

  localparam longint unsigned MCLK_HZ   = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS = 40;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b01,
    CAL_RUN  = 2'b10
  } mccr_cal_state_t;

endpackage : mccr_pkg

// [dv/meter_calibration_config_regs_bench.sv]
`timescale 1ns/1ps
module meter_calibration_config_regs_bench;
  import mccr_pkg::*;
  // Divider of 8 brings the third pulse clamp below the reset rate
  localparam int unsigned KD     = 8;
  localparam logic [23:0] P3_LIM = 24'hBEBC20;
  localparam logic [5:0]  RIX [0:6] = '{6'h10, 6'h11, 6'h12, 6'h14, 6'h15, 6'h17, 6'h18};
  localparam logic [23:0] RRST[0:6] = '{24'h000000, 24'h000000, 24'hFA0000, 24'h500000,
                                        24'h000200, 24'h000000, 24'h000000};
  localparam logic [23:0] RWR [0:6] = '{24'hA5A5A5, 24'h5A5A5A, 24'h000100, 24'h9ABCDE,
                                        24'h000123, 24'hFFFFFF, 24'hFFFFFF};
  localparam logic [23:0] RBK [0:6] = '{24'hA5A5A5, 24'h5A5A5A, 24'h000100, 24'h9ABCDE,
                                        24'h000123, 24'h7FFFFF, 24'h7FFFFF};
  logic        MCLK       = 1'b0;
  logic        RST_B      = 1'b0;
  logic        PSEL       = 1'b0;
  logic        PENABLE    = 1'b0;
  logic        PWRITE     = 1'b0;
  logic [7:0]  PADDR      = 8'h00;
  logic [31:0] PWDATA     = 32'h0;
  logic        ADC_STROBE = 1'b0;
  logic [23:0] I_SAMPLE   = 24'h0;
  logic [23:0] V_SAMPLE   = 24'h0;
  logic        TEMP_VALID = 1'b0;
  logic [23:0] TEMP_DATA  = 24'h0;
  logic        FMT_ALT    = 1'b0;
  logic        FMT_MECH   = 1'b0;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic [23:0] I_AC_OFFSET;
  logic [23:0] V_AC_OFFSET;
  logic [23:0] SYS_GAIN;
  logic [23:0] P3_RATE;
  logic [23:0] E12_LOW_WIDTH;
  logic        E12_WIDTH_EN;
  logic        SAMPLE_TICK;
  logic        DATA_READY;
  logic        VOLTAGE_SAG;
  logic        CAL_BUSY;
  logic [31:0] rd;
  logic        er;
  int          err_count  = 0;
  int          n_compared = 0;
  int          cycles     = 0;

  always #20 MCLK = ~MCLK;

  mccr_regs #(.K_DIV(KD)) uut (
    .MCLK(MCLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .ADC_STROBE(ADC_STROBE), .I_SAMPLE(I_SAMPLE), .V_SAMPLE(V_SAMPLE),
    .TEMP_VALID(TEMP_VALID), .TEMP_DATA(TEMP_DATA), .FMT_ALT(FMT_ALT), .FMT_MECH(FMT_MECH),
    .I_AC_OFFSET(I_AC_OFFSET), .V_AC_OFFSET(V_AC_OFFSET), .SYS_GAIN(SYS_GAIN),
    .P3_RATE(P3_RATE), .E12_LOW_WIDTH(E12_LOW_WIDTH), .E12_WIDTH_EN(E12_WIDTH_EN),
    .SAMPLE_TICK(SAMPLE_TICK), .DATA_READY(DATA_READY), .VOLTAGE_SAG(VOLTAGE_SAG),
    .CAL_BUSY(CAL_BUSY)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // Generous ceiling: the two tick periods dominate the run
  always @(posedge MCLK) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  ////////////////////////////////////////////////////////////////////////////////
  // Request held until PREADY is sampled high; data taken at that edge only
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    int n;
    @(posedge MCLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= wr;
    PADDR   <= {idx, 2'b00};
    PWDATA  <= wd;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    chk("pready wait", n, 32'h00000001);
  endtask : apb

  task automatic strobe(input logic [23:0] i, input logic [23:0] v, input int cnt);
    repeat (cnt) begin
      @(posedge MCLK);
      ADC_STROBE <= 1'b1;
      I_SAMPLE   <= i;
      V_SAMPLE   <= v;
      @(posedge MCLK);
      ADC_STROBE <= 1'b0;
    end
    #1;
  endtask : strobe

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values;
    repeat (2) @(posedge MCLK);
    #1;
    chk("p3 clamped at reset", P3_RATE, P3_LIM);
    for (int k = 0; k < 7; k++) begin
      apb(1'b0, RIX[k], 32'h0);
      chk("reset value", rd, {8'h00, RRST[k]});
    end
  endtask : t_reset_values

  task automatic t_readwrite;
    for (int k = 0; k < 7; k++) begin
      apb(1'b1, RIX[k], {8'hFF, RWR[k]});
    end
    for (int k = 0; k < 7; k++) begin
      apb(1'b0, RIX[k], 32'h0);
      chk("readback", rd, {8'h00, RBK[k]});
    end
    #1;
    chk("i offset port", I_AC_OFFSET, 24'hA5A5A5);
    chk("gain port", SYS_GAIN, 24'h9ABCDE);
    chk("p3 port", P3_RATE, 24'h000100);
    apb(1'b0, 6'h16, 32'h0);
    chk("unmapped error", {31'h0, er}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, IDX_P3_RATE, 32'h00FFFFFF);
    apb(1'b0, IDX_P3_RATE, 32'h0);
    chk("p3 reg kept", rd, 32'h00FFFFFF);
    chk("p3 clamp", P3_RATE, P3_LIM);
    apb(1'b1, IDX_SAG_COUNT, 32'h0);
  endtask : t_readwrite

  task automatic t_temp;
    @(posedge MCLK);
    TEMP_VALID <= 1'b1;
    TEMP_DATA  <= 24'hFF8000;
    @(posedge MCLK);
    TEMP_VALID <= 1'b0;
    apb(1'b1, IDX_TEMP, 32'h00123456);
    apb(1'b0, IDX_TEMP, 32'h0);
    chk("temperature", rd, 32'h00FF8000);
    chk("temperature err", {31'h0, er}, 32'h0);
  endtask : t_temp

  task automatic t_width;
    for (int m = 0; m < 3; m++) begin
      @(posedge MCLK);
      FMT_ALT  <= (m == 1);
      FMT_MECH <= (m == 2);
      repeat (2) @(posedge MCLK);
      #1;
      chk("low width", E12_LOW_WIDTH, (m == 0) ? 24'h0 : 24'h000123);
      chk("width enable", {31'h0, E12_WIDTH_EN}, (m == 0) ? 32'h0 : 32'h1);
    end
  endtask : t_width

  task automatic t_tick;
    int n;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (SAMPLE_TICK !== 1'b1 && n < 9000);
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (SAMPLE_TICK !== 1'b1 && n < 9000);
    chk("tick period", n, 1024 * KD);
  endtask : t_tick

  // N = 1 gives 6*1+30 = 36 strobes
  task automatic t_cal;
    apb(1'b1, IDX_CYCLE_COUNT, 32'h1);
    apb(1'b1, IDX_CAL_CMD, 32'h1);
    apb(1'b0, IDX_CAL_CMD, 32'h0);
    chk("busy bit", rd, 32'h1);
    strobe(24'h100000, 24'hF00000, 35);
    chk("busy early", {31'h0, CAL_BUSY}, 32'h1);
    chk("offset early", I_AC_OFFSET, 24'hA5A5A5);
    strobe(24'h100000, 24'hF00000, 1);
    chk("busy done", {31'h0, CAL_BUSY}, 32'h0);
    chk("i offset sign", {31'h0, I_AC_OFFSET[23]}, 32'h1);
    chk("v offset sign", {31'h0, V_AC_OFFSET[23]}, 32'h0);
    chk("v offset new", {31'h0, V_AC_OFFSET !== 24'h5A5A5A}, 32'h1);
    @(posedge MCLK);
    #1;
    chk("data ready", {31'h0, DATA_READY}, 32'h1);
    apb(1'b0, IDX_STATUS, 32'h0);
    chk("status ready", rd, 32'h00800000);
    apb(1'b1, IDX_STATUS, 32'h00800000);
    apb(1'b0, IDX_STATUS, 32'h0);
    chk("status cleared", rd, 32'h0);
  endtask : t_cal

  // Magnitude of a negative sample below the level flags a sag
  task automatic t_sag;
    apb(1'b1, IDX_SAG_LEVEL, 32'h00400000);
    apb(1'b1, IDX_SAG_COUNT, 32'h4);
    strobe(24'h0, 24'hF00000, 4);
    @(posedge MCLK);
    #1;
    chk("sag flag", {31'h0, VOLTAGE_SAG}, 32'h1);
    apb(1'b0, IDX_STATUS, 32'h0);
    chk("status sag", rd, 32'h00000002);
    apb(1'b1, IDX_STATUS, 32'h00000002);
    strobe(24'h0, 24'h600000, 4);
    @(posedge MCLK);
    #1;
    chk("no sag above", {31'h0, VOLTAGE_SAG}, 32'h0);
    apb(1'b1, IDX_SAG_COUNT, 32'h0);
    strobe(24'h0, 24'h000000, 6);
    apb(1'b0, IDX_STATUS, 32'h0);
    chk("sag disabled", rd, 32'h0);
  endtask : t_sag

  task automatic t_rereset;
    @(posedge MCLK);
    RST_B <= 1'b0;
    repeat (2) @(posedge MCLK);
    #1;
    chk("offset in reset", I_AC_OFFSET, 24'h0);
    chk("gain in reset", SYS_GAIN, 24'h500000);
    @(posedge MCLK);
    RST_B <= 1'b1;
    apb(1'b0, IDX_PULSE_WIDTH, 32'h0);
    chk("width after reset", rd, 32'h00000200);
  endtask : t_rereset

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge MCLK);
    RST_B <= 1'b1;
    t_reset_values();
    t_readwrite();
    t_temp();
    t_width();
    t_tick();
    t_cal();
    t_sag();
    t_rereset();
    give_verdict();
  end
endmodule : meter_calibration_config_regs_bench
